// >>> verilog/pcd_consts.svh
`ifndef PCD_CONSTS_SVH
`define PCD_CONSTS_SVH

`define PCD_ADDR_RISE     4'h0
`define PCD_ADDR_FALL     4'h1
`define PCD_ADDR_FLAGS    4'h2
`define PCD_ADDR_CTRL     4'h3
`define PCD_RESET_BYTE    8'h00
`define PCD_CTRL_IE_BIT   0
`define PCD_CTRL_GIE_BIT  1
`define PCD_CTRL_STAT_BIT 2

`endif

// >>> verilog/pcd_pkg.sv
package pcd_pkg;
   typedef logic [7:0] pcd_byte_t;
   typedef logic [3:0] pcd_addr_t;
endpackage

// >>> verilog/pcd_top.sv
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "pcd_consts.svh"

// Summary of operation
// [RL1] Enabled rising edge on a pin sets that pin's change flag.
// [RL2] Enabled falling edge on a pin sets that pin's change flag.
// [RL3] Edges of a disabled polarity are ignored and set no flag.
// [RL4] Enabled edge sets the pin flag and the combined change status.
// [RL5] Software may clear flags; cleared flag stays zero until next enabled edge or a write of one.
// [RL6] Rise, fall and flag registers reset to zero on every reset.
// [RL7] Flags set on edges regardless of interrupt enables.
// [RL8] Combined status follows any flag; request needs both enables.
module pcd_top #(
   parameter int WIDTH = 8
) (
   input  wire logic             CLOCK,
   input  wire logic             RESET_N,
   input  wire logic [WIDTH-1:0] WATCHED_PORT_PIN,
   input  wire pcd_pkg::pcd_addr_t ADDR,
   input  wire pcd_pkg::pcd_byte_t WDATA,
   input  wire logic             WR,
   input  wire logic             RD,
   output logic      [7:0]       RDATA,
   output logic                  COMBINED_CHANGE_STATUS,
   output logic                  CHANGE_IRQ
);

   logic [WIDTH-1:0] pin_q,  pin_d;
   logic [WIDTH-1:0] rise_q, rise_d;
   logic [WIDTH-1:0] fall_q, fall_d;
   logic [WIDTH-1:0] flag_q, flag_d;
   logic             ie_q,   ie_d;
   logic             gie_q,  gie_d;
   logic             stat_q, stat_d;
   logic             irq_q,  irq_d;
   logic [7:0]       rdata_q, rdata_d;
   logic [WIDTH-1:0] hit;
   logic [7:0]       ctrl_rd;

   always_comb begin
      pin_d   = WATCHED_PORT_PIN;
      rise_d  = rise_q;
      fall_d  = fall_q;
      ie_d    = ie_q;
      gie_d   = gie_q;
      // Enables alone gate detection, never the interrupt enables
      hit = (rise_q & WATCHED_PORT_PIN & ~pin_q)      // see [RL1] see [RL3] see [RL7]
          | (fall_q & ~WATCHED_PORT_PIN & pin_q);     // see [RL2] see [RL3]
      flag_d = flag_q;
      if (WR && ADDR == `PCD_ADDR_RISE) begin
         rise_d = WDATA[WIDTH-1:0];
      end
      if (WR && ADDR == `PCD_ADDR_FALL) begin
         fall_d = WDATA[WIDTH-1:0];
      end
      if (WR && ADDR == `PCD_ADDR_FLAGS) begin
         flag_d = WDATA[WIDTH-1:0]; // see [RL5]
      end
      if (WR && ADDR == `PCD_ADDR_CTRL) begin
         ie_d  = WDATA[`PCD_CTRL_IE_BIT];
         gie_d = WDATA[`PCD_CTRL_GIE_BIT];
      end
      // Set wins over a simultaneous software clear
      flag_d = flag_d | hit; // see [RL4] see [RL5]
      stat_d = |flag_d; // see [RL8] see [RL4]
      irq_d  = stat_d & ie_d & gie_d; // see [RL8]
      ctrl_rd = 8'h00;
      ctrl_rd[`PCD_CTRL_IE_BIT]   = ie_q;
      ctrl_rd[`PCD_CTRL_GIE_BIT]  = gie_q;
      ctrl_rd[`PCD_CTRL_STAT_BIT] = stat_q;
      rdata_d = 8'h00;
      if (RD) begin
         case (ADDR)
            `PCD_ADDR_RISE:  rdata_d = 8'(rise_q);
            `PCD_ADDR_FALL:  rdata_d = 8'(fall_q);
            `PCD_ADDR_FLAGS: rdata_d = 8'(flag_q);
            `PCD_ADDR_CTRL:  rdata_d = ctrl_rd;
            default:         rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         // Zero edge history, but rise enables also reset to zero: a pin high at release sets no flag
         pin_q   <= '0;
         rise_q  <= '0; // see [RL6]
         fall_q  <= '0; // see [RL6]
         flag_q  <= '0; // see [RL6]
         ie_q    <= 1'b0;
         gie_q   <= 1'b0;
         stat_q  <= 1'b0;
         irq_q   <= 1'b0;
         rdata_q <= `PCD_RESET_BYTE;
      end else begin
         pin_q   <= pin_d;
         rise_q  <= rise_d;
         fall_q  <= fall_d;
         flag_q  <= flag_d;
         ie_q    <= ie_d;
         gie_q   <= gie_d;
         stat_q  <= stat_d;
         irq_q   <= irq_d;
         rdata_q <= rdata_d;
      end
   end

   assign RDATA                  = rdata_q;
   assign COMBINED_CHANGE_STATUS = stat_q;
   assign CHANGE_IRQ             = irq_q;

endmodule
`default_nettype wire

// >>> tb/pcd_checker.sv
`timescale 1ns/100ps
`default_nettype none
`include "pcd_consts.svh"
module pcd_checker (input wire logic CLOCK, RESET_N, WR, RD, COMBINED_CHANGE_STATUS, CHANGE_IRQ,
   input wire logic [7:0] WATCHED_PORT_PIN, WDATA, RDATA, input wire pcd_pkg::pcd_addr_t ADDR);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RESET_N);
   wire logic s = COMBINED_CHANGE_STATUS;
   wire logic w = WR && ADDR == `PCD_ADDR_FLAGS;
   AST_RZ: assert property (!$past(RD) |-> RDATA == 0) else $error("rdata");
   AST_RS: assert property ($rose(RESET_N) |-> !s) else $error("reset");
   AST_CL: assert property (w && !WDATA && $stable(WATCHED_PORT_PIN) |=> !s) else $error("clr");
   AST_ST: assert property (w && WDATA |=> s) else $error("set");
   AST_HD: assert property (s && !w |=> s) else $error("hold");
   AST_NE: assert property (!s && !w && $stable(WATCHED_PORT_PIN) |=> !s) else $error("new");
   AST_IQ: assert property (CHANGE_IRQ |-> s) else $error("irq");
   AST_RF: assert property ($past(RD && ADDR == `PCD_ADDR_FLAGS) |-> |RDATA == $past(s)) else $error("rd");
endmodule
bind pcd_top pcd_checker pcd_checker_inst (.*);
`default_nettype wire

// >>> tb/pcd_pin_model.sv
`timescale 1ns/100ps
`default_nettype none
module pcd_pin_model (input wire logic clk, input wire logic [7:0] lv, output var logic [7:0] pins);
   always_ff @(posedge clk) pins <= lv;
endmodule
`default_nettype wire

// >>> tb/pcd_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define C(a, e) begin num_checks++; if ((a) !== (e)) begin n_mismatch++; $display("MISMATCH %0t value differs", $time); end end
module pcd_tb_top;
   logic CLOCK = 0, RESET_N = 0, WR = 0, RD = 0, COMBINED_CHANGE_STATUS, CHANGE_IRQ;
   logic [7:0] lv = 0, WATCHED_PORT_PIN, WDATA = 0, RDATA;
   logic [3:0] ADDR = 0;
   logic [39:0] t [4] = '{40'hFF_0000_FFFF, 40'h00_FFFF_00FF, 40'h0F_A500_FF0F, 40'h3C_C3F0_0FCC};
   int n_mismatch = 0, num_checks = 0, c = 0;
   pcd_top pcd_top_inst (.*);
   pcd_pin_model pcd_pin_model_inst (.clk(CLOCK), .lv(lv), .pins(WATCHED_PORT_PIN));
   task automatic op(logic r, logic [3:0] a, logic [7:0] d);
      @(posedge CLOCK) {RD, WR, ADDR, WDATA} <= {r, !r, a, d};
      @(posedge CLOCK) {RD, WR} <= 2'b00;
      @(negedge CLOCK) if (r) `C(RDATA, d)
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial forever #5 CLOCK = ~CLOCK;
   always @(posedge CLOCK) if (++c > 999) begin n_mismatch++; print_verdict; end
   initial begin
      repeat (10) @(posedge CLOCK);
      RESET_N <= 1;
      op(1, 2, 8'h00);
      foreach (t[i]) begin
         op(0, 0, t[i][39:32]);
         op(0, 1, t[i][31:24]);
         lv <= t[i][23:16];
         repeat (3) @(posedge CLOCK);
         op(0, 2, 8'h00);
         lv <= t[i][15:8];
         repeat (3) @(posedge CLOCK);
         op(1, 2, t[i][7:0]);
         `C(COMBINED_CHANGE_STATUS, |t[i][7:0])
         $display("row %0d done", i);
      end
      op(0, 3, 8'h03);
      `C(CHANGE_IRQ, 1'b1)
      op(0, 2, 8'h80);
      op(1, 2, 8'h80);
      $display("irq test done");
      // Edge and software clear in one cycle: the edge must win
      op(0, 0, 8'hFF);
      lv <= 8'hFF;
      op(0, 2, 8'h00);
      op(1, 2, 8'hF0);
      `C(CHANGE_IRQ, 1'b1)
      op(0, 2, 8'h00);
      `C(COMBINED_CHANGE_STATUS, 1'b0)
      `C(CHANGE_IRQ, 1'b0)
      op(1, 3, 8'h03);
      op(0, 4'h9, 8'hFF);
      op(1, 4'h9, 8'h00);
      $display("clear test done");
      // Reset in mid-run
      op(0, 1, 8'hFF);
      @(posedge CLOCK) RESET_N <= 0;
      repeat (2) @(posedge CLOCK);
      RESET_N <= 1;
      @(negedge CLOCK);
      `C(COMBINED_CHANGE_STATUS, 1'b0)
      `C(CHANGE_IRQ, 1'b0)
      op(1, 0, 8'h00);
      op(1, 1, 8'h00);
      op(1, 2, 8'h00);
      op(1, 3, 8'h00);
      $display("reset test done");
      print_verdict;
   end
endmodule
`default_nettype wire
